// file: dtes_pkg.sv
// Purpose: constants for the disk/tape detailed error status block
// Assumes: one clock, synchronous active-low reset
// Notes: register offsets are word indices on the plain register port
package dtes_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] DTES_OFS_FUNC_ERR = 4'h0;
  localparam logic [3:0] DTES_OFS_ACC_ERR = 4'h1;
  localparam logic [3:0] DTES_OFS_DATA_ERR = 4'h2;
  localparam logic [3:0] DTES_OFS_OP_STATUS = 4'h3;
  localparam logic [3:0] DTES_OFS_CONTROL = 4'h4;
  localparam logic [3:0] DTES_OFS_FUNC_CODE = 4'h5;

  localparam logic [7:0] DTES_STATUS_RESET = 8'h00;
  localparam logic [7:0] DTES_UNMAPPED_DATA = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DTES_OPS_ERROR_BIT = 7;
  localparam int DTES_OPS_HARD_BIT = 6;
  localparam int DTES_CTL_TAPE_BIT = 0;
  localparam int DTES_CTL_INHIBIT_BIT = 1;
  localparam int DTES_CTL_PARITY_MOD_BIT = 2;

  // highest defined controller function code (codes above are invalid)
  localparam logic [7:0] DTES_MAX_FUNC_CODE = 8'h0F;

  typedef enum logic [1:0] {DTES_IDLE, DTES_BUSY, DTES_RECAL} dtes_state_t;

endpackage : dtes_pkg

// file: dtes_status.sv
// Purpose: builds the three detailed error status bytes and the operation status summary
// Assumes: condition inputs are synchronous levels, valid while a function runs
// Notes: status bytes clear at function start and latch conditions until completion
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps

// Operation
// - any status bit sets error-occurred bit
// - bytes zero/one set hard bit when a hard condition is seen
// - undefined function code sets byte0 bit0
// - tape module/drive function invalid bits
// - memory test fail, disk only
// - checksum fail, controller or tape module
// - drive busy off-line sets byte0 bit5
// - illegal code, alternate misuse, absent tape
// - end of medium before count met
// - sector size or tape length error
// - diagnostic fault, disk only
// - no index or tape module timeout
// - byte1 bit3 summarises function-code errors
// - sector not found or cartridge missing
// - invalid address and write protected bits
// - unit not ready sets byte1 bit6
// - byte2 bit0 zero; parity only capable module
// - tape retried success, tape only
// - data and identifier ecc errors, tape data
// - drive fault sets byte2 bit5
// - cylinder miscompare or tape over/under-run
// - seek error, recalibrate, re-seek unless retries inhibited
module dtes_status
  import dtes_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // function sequencing
  input wire logic func_start,
  input wire logic func_done,
  // conditions (levels sampled while busy)
  input wire logic cond_ram_fail,
  input wire logic cond_rom_fail,
  input wire logic cond_tape_rom_fail,
  input wire logic cond_mod_func_bad,
  input wire logic cond_drv_func_bad,
  input wire logic cond_drive_busy,
  input wire logic cond_illegal_param,
  input wire logic cond_alt_misuse,
  input wire logic cond_tape_absent,
  input wire logic cond_end_medium,
  input wire logic cond_sector_size,
  input wire logic cond_length_err,
  input wire logic cond_diag_fault,
  input wire logic cond_no_index,
  input wire logic cond_mod_timeout,
  input wire logic cond_sector_missing,
  input wire logic cond_no_cartridge,
  input wire logic cond_bad_address,
  input wire logic cond_not_ready,
  input wire logic cond_write_prot,
  input wire logic cond_retried_ok,
  input wire logic cond_parity_err,
  input wire logic cond_data_ecc,
  input wire logic cond_id_ecc,
  input wire logic cond_tape_data_err,
  input wire logic cond_drive_fault,
  input wire logic cond_cyl_miscompare,
  input wire logic cond_buffer_run,
  input wire logic cond_seek_err,
  input wire logic cond_hard,
  input wire logic recal_done,
  // outputs
  output logic [7:0] op_status,
  output logic status_valid,
  output logic recal_req,
  output logic reseek_req
);

  // ------------------------------------------------------------
  // function classification
  // ------------------------------------------------------------
  // undefined code is a compare against the top defined code
  function automatic logic func_undefined(input logic [7:0] code);
    return code > DTES_MAX_FUNC_CODE;
  endfunction

  dtes_state_t state;
  dtes_state_t next_state;
  logic [7:0] func_err;
  logic [7:0] acc_err;
  logic [7:0] data_err;
  logic [7:0] control;
  logic [7:0] func_code;
  logic hard_seen;

  wire is_tape = control[DTES_CTL_TAPE_BIT];
  wire is_disk = ~is_tape;
  wire inhibit_retries = control[DTES_CTL_INHIBIT_BIT];
  wire parity_module = control[DTES_CTL_PARITY_MOD_BIT];
  wire busy = (state != DTES_IDLE);
  wire start = func_start & ~busy;

  // ------------------------------------------------------------
  // condition mapping into byte positions
  // ------------------------------------------------------------
  // disk/tape gating done here so latched bytes never hold the wrong meaning
  wire [7:0] set_func;
  wire [7:0] set_acc;
  wire [7:0] set_data;
  wire fc_err_any;

  assign set_func[0] = func_undefined(func_code);
  assign set_func[1] = is_tape & cond_mod_func_bad;
  assign set_func[2] = is_tape & cond_drv_func_bad;
  assign set_func[3] = is_disk & cond_ram_fail;
  assign set_func[4] = is_disk ? cond_rom_fail : cond_tape_rom_fail;
  assign set_func[5] = cond_drive_busy;
  assign set_func[6] = cond_illegal_param | (is_disk & cond_alt_misuse) | (is_tape & cond_tape_absent);
  assign set_func[7] = cond_end_medium;

  // summary reads the latched and incoming function-code errors
  assign fc_err_any = |(func_err[2:0] | set_func[2:0]);

  assign set_acc[0] = is_disk ? cond_sector_size : cond_length_err;
  assign set_acc[1] = is_disk & cond_diag_fault;
  assign set_acc[2] = is_disk ? cond_no_index : cond_mod_timeout;
  assign set_acc[3] = fc_err_any;
  assign set_acc[4] = is_disk ? cond_sector_missing : cond_no_cartridge;
  assign set_acc[5] = is_disk & cond_bad_address;
  assign set_acc[6] = cond_not_ready;
  assign set_acc[7] = cond_write_prot;

  assign set_data[0] = 1'b0;
  assign set_data[1] = is_tape & cond_retried_ok;
  assign set_data[2] = is_tape & parity_module & cond_parity_err;
  assign set_data[3] = is_disk ? cond_data_ecc : cond_tape_data_err;
  assign set_data[4] = is_disk & cond_id_ecc;
  assign set_data[5] = cond_drive_fault;
  assign set_data[6] = is_disk ? cond_cyl_miscompare : cond_buffer_run;
  assign set_data[7] = is_disk & cond_seek_err;

  wire seek_fail = is_disk & cond_seek_err & busy & (state == DTES_BUSY);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // seek error diverts to recalibrate; completion waits for it to finish
  always_comb begin
    next_state = state;
    unique case (state)
      DTES_IDLE: begin
        if (func_start) begin
          next_state = DTES_BUSY;
        end
      end
      DTES_BUSY: begin
        if (seek_fail) begin
          next_state = DTES_RECAL;
        end else if (func_done) begin
          next_state = DTES_IDLE;
        end
      end
      DTES_RECAL: begin
        if (recal_done) begin
          next_state = DTES_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= DTES_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // detailed status bytes
  // ------------------------------------------------------------
  // clear on start; conditions accumulate while busy so brief pulses are kept
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      func_err <= DTES_STATUS_RESET;
      acc_err <= DTES_STATUS_RESET;
      data_err <= DTES_STATUS_RESET;
      hard_seen <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        func_err <= DTES_STATUS_RESET;
        acc_err <= DTES_STATUS_RESET;
        data_err <= DTES_STATUS_RESET;
        hard_seen <= 1'b0;
      end else if (busy) begin
        func_err <= func_err | set_func;
        acc_err <= acc_err | set_acc;
        data_err <= data_err | set_data;
        hard_seen <= hard_seen | cond_hard;
      end
    end
  end

  // ------------------------------------------------------------
  // operation status summary and completion
  // ------------------------------------------------------------
  wire completing = busy & (next_state == DTES_IDLE);
  wire [7:0] fin_func = func_err | set_func;
  wire [7:0] fin_acc = acc_err | set_acc;
  wire [7:0] fin_data = data_err | set_data;
  wire any_err = |{fin_func, fin_acc, fin_data};
  wire hard_class = |{fin_func, fin_acc};
  wire [7:0] next_op_status = {any_err, hard_class & (hard_seen | cond_hard), 6'h00};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      op_status <= DTES_STATUS_RESET;
      status_valid <= 1'b0;
    end else if (clk_en) begin
      status_valid <= completing;
      if (start) begin
        op_status <= DTES_STATUS_RESET;
      end else if (completing) begin
        op_status <= next_op_status;
      end
    end
  end

  // recalibrate then re-seek, re-seek suppressed when retries inhibited
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      recal_req <= 1'b0;
      reseek_req <= 1'b0;
    end else if (clk_en) begin
      recal_req <= seek_fail;
      reseek_req <= (state == DTES_RECAL) & recal_done & ~inhibit_retries;
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire [7:0] rd_mux = (reg_addr == DTES_OFS_FUNC_ERR) ? func_err :
                      (reg_addr == DTES_OFS_ACC_ERR) ? acc_err :
                      (reg_addr == DTES_OFS_DATA_ERR) ? data_err :
                      (reg_addr == DTES_OFS_OP_STATUS) ? op_status :
                      (reg_addr == DTES_OFS_CONTROL) ? control :
                      (reg_addr == DTES_OFS_FUNC_CODE) ? func_code : DTES_UNMAPPED_DATA;

  // control and code writes; status bytes are read only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control <= DTES_STATUS_RESET;
      func_code <= DTES_STATUS_RESET;
      reg_rdata <= DTES_STATUS_RESET;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == DTES_OFS_CONTROL) begin
        control <= reg_wdata;
      end
      if (reg_wr && reg_addr == DTES_OFS_FUNC_CODE) begin
        func_code <= reg_wdata;
      end
      reg_rdata <= reg_rd ? rd_mux : DTES_UNMAPPED_DATA;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_error_summary: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid |-> (op_status[DTES_OPS_ERROR_BIT] == |{func_err, acc_err, data_err}))
    else $error("error bit disagrees with status bytes");
  a_hard_class: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid & ~|{func_err, acc_err} |-> !op_status[DTES_OPS_HARD_BIT])
    else $error("hard bit set without byte 0/1 error");
  a_func_undef: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & busy & ~start & func_undefined(func_code) |=> func_err[0])
    else $error("undefined function code not flagged");
  a_tape_only_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid & is_disk & $stable(control) |-> func_err[2:1] == 2'b00 && data_err[1] == 1'b0)
    else $error("tape-only bit set on disk function");
  a_summary_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid |-> acc_err[3] == |func_err[2:0])
    else $error("function code summary wrong");
  a_byte2_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_err[0] == 1'b0)
    else $error("byte 2 bit 0 nonzero");
  a_start_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & start |=> {func_err, acc_err, data_err} == 24'h000000)
    else $error("status not cleared at start");
  sequence s_recal_done;
    clk_en & (state == DTES_RECAL) & recal_done;
  endsequence
  a_reseek_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_recal_done ##1 clk_en [*1] |-> reseek_req == ~inhibit_retries || !$stable(control))
    else $error("re-seek not gated by retry inhibit");
  a_recal_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & seek_fail |=> recal_req && data_err[7])
    else $error("seek error did not recalibrate");

  // ------------------------------------------------------------
  // completion and summary
  // ------------------------------------------------------------
  // completion is one enabled edge that leaves busy for idle
  sequence s_func_complete;
    clk_en & busy & (next_state == DTES_IDLE);
  endsequence
  // valid lasts one enabled cycle, so a slow poller can miss it
  a_valid_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_func_complete ##1 clk_en |-> status_valid ##1 !status_valid)
    else $error("completion strobe not one cycle long");
  // hard bit is the hard class seen over the whole function
  a_hard_exact: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid |-> op_status[DTES_OPS_HARD_BIT] == (|{func_err, acc_err} & hard_seen))
    else $error("hard bit disagrees with class");
  // with no function running the bytes keep the last result
  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !busy & !func_start |=> $stable({func_err, acc_err, data_err}))
    else $error("status bytes changed between functions");

  // ------------------------------------------------------------
  // latching of single conditions
  // ------------------------------------------------------------
  // tape module checksum lands in the shared checksum bit
  a_tape_rom: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & busy & is_tape & cond_tape_rom_fail |=> func_err[4])
    else $error("tape module checksum fail not flagged");
  // busy drive refusal applies to disk and tape alike
  a_drive_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & busy & cond_drive_busy |=> func_err[5])
    else $error("busy drive not flagged");
  // end of medium counts for either function class
  a_end_medium: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & busy & cond_end_medium |=> func_err[7])
    else $error("end of medium not flagged");
  // no answer from the addressed unit
  a_unit_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & busy & cond_not_ready |=> acc_err[6])
    else $error("unit not ready not flagged");
  // device hardware fault is reported for both classes
  a_drive_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & busy & cond_drive_fault |=> data_err[5])
    else $error("drive fault not flagged");
  // parity bit only exists with the parity-capable module
  a_parity_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid & ~parity_module & $stable(control) |-> !data_err[2])
    else $error("parity bit set without capable module");
  // memory test, diagnostic, identifier ecc and seek bits must stay clear after a tape function
  a_disk_only_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status_valid & is_tape & $stable(control) |-> !func_err[3] && !acc_err[1] && !data_err[4] && !data_err[7])
    else $error("disk-only bit set on tape function");

  // ------------------------------------------------------------
  // seek recovery and register port
  // ------------------------------------------------------------
  // recalibration end finishes the function in the same step
  a_recal_completes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_recal_done |=> status_valid && state == DTES_IDLE)
    else $error("recalibration end did not complete function");
  // an inhibited retry never produces a re-seek
  a_inhibit_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & inhibit_retries |=> !reseek_req)
    else $error("re-seek issued with retries inhibited");
  // read data stand for one cycle only, idle reads as zero
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en & !reg_rd |=> reg_rdata == DTES_UNMAPPED_DATA)
    else $error("read data outside read cycle");
  // a low enable freezes sequencer, summary and read data
  a_enable_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(state) && $stable(op_status) && $stable(reg_rdata))
    else $error("state moved while enable low");

endmodule // dtes_status

// file: dtes_far_model.sv
// Purpose: far-side model of the disk drives and tape module feeding the error status block
// Assumes: one clock, synchronous active-low reset; conditions are levels while a function runs
// Notes: completion delay set per function, so both prompt and slow answers are exercised
`timescale 1ns/100ps

module dtes_far_model #(
  parameter int RECAL_DLY = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic func_start,
  input wire logic recal_req,
  input wire logic [29:0] cond_mask,
  input wire logic [7:0] done_dly,
  output logic [29:0] cond,
  output logic func_done,
  output logic recal_done
);
  // ------------------------------------------------------------
  // function and recalibration sequencing
  // ------------------------------------------------------------
  logic active;
  logic [7:0] cnt;
  logic [7:0] rcnt;

  // conditions only while a function runs, quiet between functions
  assign cond = active ? cond_mask : 30'h00000000;

  // done_dly must be at least one; a seek fault ends the transfer and starts a recalibration
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      active <= 1'b0;
      cnt <= 8'h00;
      rcnt <= 8'h00;
      func_done <= 1'b0;
      recal_done <= 1'b0;
    end else begin
      func_done <= 1'b0;
      recal_done <= 1'b0;
      if (recal_req) begin
        active <= 1'b0;
        rcnt <= RECAL_DLY[7:0];
      end else if (func_start && !active) begin
        active <= 1'b1;
        cnt <= done_dly;
      end else if (active && func_done) begin
        active <= 1'b0;
      end else if (active) begin
        cnt <= cnt - 8'h01;
        func_done <= (cnt == 8'h01);
      end
      if (rcnt != 8'h00) begin
        rcnt <= rcnt - 8'h01;
        recal_done <= (rcnt == 8'h01);
      end
    end
  end
endmodule // dtes_far_model

// file: testbench.sv
// Purpose: self-checking bench for the detailed error status block
// Assumes: 100 MHz clock, synchronous active-low reset held 12 cycles
// Notes: table of single-condition functions, then codes, hard class, seek recovery, refusals
`timescale 1ns/100ps

module testbench import dtes_pkg::*; ;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  typedef struct packed {logic [2:0] ctl; logic [4:0] idx; logic [7:0] e0; logic [7:0] e1; logic [7:0] e2;} dtes_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic func_start = 1'b0;
  logic [29:0] cond_mask = 30'h00000000;
  logic [7:0] done_dly = 8'h01;
  logic [7:0] reg_rdata, op_status;
  logic status_valid, recal_req, reseek_req, func_done, recal_done;
  logic [29:0] cv;
  int n_errors = 0;
  int cmp_count = 0;
  int n_recal = 0;
  int n_reseek = 0;
  always #5 ref_clk = ~ref_clk;

  dtes_status dtes_status_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .func_start(func_start),
    .func_done(func_done), .cond_ram_fail(cv[0]), .cond_rom_fail(cv[1]), .cond_tape_rom_fail(cv[2]),
    .cond_mod_func_bad(cv[3]), .cond_drv_func_bad(cv[4]), .cond_drive_busy(cv[5]), .cond_illegal_param(cv[6]),
    .cond_alt_misuse(cv[7]), .cond_tape_absent(cv[8]), .cond_end_medium(cv[9]), .cond_sector_size(cv[10]),
    .cond_length_err(cv[11]), .cond_diag_fault(cv[12]), .cond_no_index(cv[13]), .cond_mod_timeout(cv[14]),
    .cond_sector_missing(cv[15]), .cond_no_cartridge(cv[16]), .cond_bad_address(cv[17]),
    .cond_not_ready(cv[18]), .cond_write_prot(cv[19]), .cond_retried_ok(cv[20]), .cond_parity_err(cv[21]),
    .cond_data_ecc(cv[22]), .cond_id_ecc(cv[23]), .cond_tape_data_err(cv[24]), .cond_drive_fault(cv[25]),
    .cond_cyl_miscompare(cv[26]), .cond_buffer_run(cv[27]), .cond_seek_err(cv[28]), .cond_hard(cv[29]),
    .recal_done(recal_done), .op_status(op_status), .status_valid(status_valid), .recal_req(recal_req),
    .reseek_req(reseek_req));

  dtes_far_model dtes_far_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .func_start(func_start),
    .recal_req(recal_req), .cond_mask(cond_mask), .done_dly(done_dly), .cond(cv), .func_done(func_done),
    .recal_done(recal_done));

  // pulse counters for the recovery outputs
  always @(posedge ref_clk) begin
    if (recal_req === 1'b1) n_recal <= n_recal + 1;
    if (reseek_req === 1'b1) n_reseek <= n_reseek + 1;
  end

  // ------------------------------------------------------------
  // table: mode (bit0 tape, bit1 no retries, bit2 parity module), condition (1F none), bytes 0..2
  // ------------------------------------------------------------
  localparam int NROWS = 35;
  localparam dtes_row_t ROWS [NROWS] = '{
    '{3'h0,5'h00,8'h08,8'h00,8'h00}, '{3'h1,5'h00,8'h00,8'h00,8'h00}, '{3'h0,5'h01,8'h10,8'h00,8'h00},
    '{3'h1,5'h02,8'h10,8'h00,8'h00}, '{3'h1,5'h03,8'h02,8'h08,8'h00}, '{3'h0,5'h03,8'h00,8'h00,8'h00},
    '{3'h1,5'h04,8'h04,8'h08,8'h00}, '{3'h0,5'h05,8'h20,8'h00,8'h00}, '{3'h0,5'h06,8'h40,8'h00,8'h00},
    '{3'h0,5'h07,8'h40,8'h00,8'h00}, '{3'h1,5'h08,8'h40,8'h00,8'h00}, '{3'h0,5'h09,8'h80,8'h00,8'h00},
    '{3'h0,5'h0A,8'h00,8'h01,8'h00}, '{3'h1,5'h0B,8'h00,8'h01,8'h00}, '{3'h0,5'h0C,8'h00,8'h02,8'h00},
    '{3'h1,5'h0C,8'h00,8'h00,8'h00}, '{3'h0,5'h0D,8'h00,8'h04,8'h00}, '{3'h1,5'h0E,8'h00,8'h04,8'h00},
    '{3'h0,5'h0F,8'h00,8'h10,8'h00}, '{3'h1,5'h10,8'h00,8'h10,8'h00}, '{3'h0,5'h11,8'h00,8'h20,8'h00},
    '{3'h0,5'h12,8'h00,8'h40,8'h00}, '{3'h0,5'h13,8'h00,8'h80,8'h00}, '{3'h1,5'h14,8'h00,8'h00,8'h02},
    '{3'h0,5'h14,8'h00,8'h00,8'h00}, '{3'h1,5'h15,8'h00,8'h00,8'h00}, '{3'h5,5'h15,8'h00,8'h00,8'h04},
    '{3'h0,5'h16,8'h00,8'h00,8'h08}, '{3'h0,5'h17,8'h00,8'h00,8'h10}, '{3'h1,5'h18,8'h00,8'h00,8'h08},
    '{3'h0,5'h19,8'h00,8'h00,8'h20}, '{3'h0,5'h1A,8'h00,8'h00,8'h40}, '{3'h1,5'h1B,8'h00,8'h00,8'h40},
    '{3'h1,5'h1C,8'h00,8'h00,8'h00}, '{3'h0,5'h1F,8'h00,8'h00,8'h00}};

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // strobes are one cycle; a gap follows so no signal is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  // one function: mode and code, conditions while running, then summary and detailed bytes
  task automatic run_fn(input dtes_row_t r, input logic [7:0] fc, input logic hard, input logic [7:0] dly);
    logic [7:0] exp_op;
    int i;
    exp_op = {|{r.e0, r.e1, r.e2}, hard & (|{r.e0, r.e1}), 6'h00};
    wr(DTES_OFS_CONTROL, {5'h00, r.ctl});
    wr(DTES_OFS_FUNC_CODE, fc);
    cond_mask <= {hard, 29'h00000000} | (30'h00000001 << r.idx);
    done_dly <= dly;
    @(posedge ref_clk);
    func_start <= 1'b1;
    @(posedge ref_clk);
    func_start <= 1'b0;
    for (i = 0; i < 300 && status_valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (status_valid !== 1'b1) begin
      n_errors++;
      $display("unexpected status_valid: expected 1 seen %b", status_valid);
      wrap_up();
    end
    check("op_status", exp_op, op_status);
    rd(DTES_OFS_OP_STATUS, exp_op, "op_status register");
    rd(DTES_OFS_FUNC_ERR, r.e0, "function_error_status");
    rd(DTES_OFS_ACC_ERR, r.e1, "access_error_status");
    rd(DTES_OFS_DATA_ERR, r.e2, "data_error_status");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // ordinary cases, prompt and slow completion alternating
    for (int k = 0; k < NROWS; k++) begin
      run_fn(ROWS[k], 8'h00, 1'b0, k[0] ? 8'h06 : 8'h01);
    end
    check("recal count", 8'h00, n_recal[7:0]);
    // code boundary and hard classification
    run_fn('{3'h0, 5'h1F, 8'h01, 8'h08, 8'h00}, 8'h10, 1'b0, 8'h01);
    run_fn('{3'h0, 5'h1F, 8'h00, 8'h00, 8'h00}, 8'h0F, 1'b0, 8'h01);
    run_fn('{3'h0, 5'h00, 8'h08, 8'h00, 8'h00}, 8'h00, 1'b1, 8'h01);
    run_fn('{3'h0, 5'h1F, 8'h00, 8'h00, 8'h00}, 8'h00, 1'b1, 8'h01);
    // seek fault: recalibrate, then re-seek only while retries are allowed
    run_fn('{3'h0, 5'h1C, 8'h00, 8'h00, 8'h80}, 8'h00, 1'b0, 8'h08);
    run_fn('{3'h2, 5'h1C, 8'h00, 8'h00, 8'h80}, 8'h00, 1'b0, 8'h08);
    check("recal count", 8'h02, n_recal[7:0]);
    check("reseek count", 8'h01, n_reseek[7:0]);
    // status bytes refuse writes; an unmapped index reads as idle data
    wr(DTES_OFS_DATA_ERR, 8'h00);
    rd(DTES_OFS_DATA_ERR, 8'h80, "data_error_status after write");
    rd(4'hF, DTES_UNMAPPED_DATA, "unmapped read");
    // enable low: a write strobe in that window must be lost
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(DTES_OFS_FUNC_CODE, 8'h33);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(DTES_OFS_FUNC_CODE, 8'h00, "func_code after frozen write");
    // reset between functions clears summary and the data error status byte
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check("op_status after reset", DTES_STATUS_RESET, op_status);
    rd(DTES_OFS_DATA_ERR, DTES_STATUS_RESET, "data_error_status after reset");
    wrap_up();
  end
endmodule // testbench
